// ===== verilog/pwm_stage_pkg.sv
// constants for the modulator and power stage control registers
// assumes a 40 MHz mclk and a 32-bit APB register port
`default_nettype none
package pwm_stage_pkg;
   // ==========================================================
   // clock and time base
   localparam int unsigned CLK_PERIOD_NS   = 25;
   localparam int unsigned TENTH_MS_NS     = 100000;
   localparam int unsigned TENTH_MS_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
   localparam int unsigned TENTHS_PER_MS   = 10;
   // ==========================================================
   // register indices and byte addresses
   localparam int unsigned ADDR_W          = 8;
   localparam logic [7:0]  IDX_START_STOP  = 8'h1a;
   localparam logic [7:0]  IDX_OSC_TRIM    = 8'h1b;
   localparam logic [7:0]  IDX_BACKEND     = 8'h1c;
   localparam logic [7:0]  IDX_INPUT_MUX   = 8'h20;
   localparam logic [7:0]  IDX_OUTPUT_MUX  = 8'h25;
   localparam int unsigned BYTE_SHIFT      = 2;
   // ==========================================================
   // reset values and fixed bits
   localparam logic [4:0]  SS_RESET        = 5'h0f;
   localparam logic [7:0]  TRIM_FIXED      = 8'h80;
   localparam int unsigned TRIM_DONE_BIT   = 6;
   localparam int unsigned TRIM_SEL_BIT    = 1;
   localparam logic [3:0]  BE_RESET        = 4'h2;
   localparam logic [3:0]  BE_MIN_CODE     = 4'h2;
   localparam logic [31:0] IN_FIXED        = 32'h00007772;
   localparam logic [2:0]  SRC_LEFT        = 3'h0;
   localparam logic [2:0]  SRC_RIGHT       = 3'h1;
   localparam logic [2:0]  SRC_ZERO        = 3'h6;
   localparam int unsigned IN_CH1_BD       = 23;
   localparam int unsigned IN_CH1_SRC      = 20;
   localparam int unsigned IN_CH2_BD       = 19;
   localparam int unsigned IN_CH2_SRC      = 16;
   localparam logic [31:0] OUT_FIXED       = 32'h01000000;
   localparam logic [7:0]  OUT_SEL_RESET   = 8'he4;
   localparam int unsigned OUT_POS_A       = 20;
   localparam int unsigned OUT_POS_B       = 16;
   localparam int unsigned OUT_POS_C       = 12;
   localparam int unsigned OUT_POS_D       = 8;
   // ==========================================================
   // period tables, start/stop in tenths of ms, back-end in ms
   function automatic logic [31:0] ss_tenths(input logic [4:0] code);
      logic [31:0] t [0:23];
      t = '{32'd165, 32'd239, 32'd314, 32'd404, 32'd539, 32'd703,
            32'd942, 32'd1257, 32'd1646, 32'd2394, 32'd3142, 32'd4039,
            32'd5386, 32'd7031, 32'd9425, 32'd12566, 32'd17281,
            32'd25136, 32'd32991, 32'd42417, 32'd56556, 32'd73837,
            32'd98973, 32'd131964};
      return (code[4:3] == 2'h0) ? 32'h0 : t[code - 5'h08];
   endfunction
   function automatic logic [31:0] be_ms(input logic [3:0] code);
      logic [31:0] t [0:7];
      t = '{32'd299, 32'd449, 32'd598, 32'd748, 32'd898, 32'd1047,
            32'd1197, 32'd1346};
      return (code > 4'h9) ? 32'd1496 : t[3'(code - BE_MIN_CODE)];
   endfunction
endpackage
`default_nettype wire

// ===== verilog/pwm_stage_control_regs.sv
// modulator and power stage control registers with their own sequencing
// assumes an APB master on mclk; shutdown, fault, samples on mclk; pins async
//
// Overview of operation
// - soft period starts on shutdown entry/exit or power-down pin change
// - start/stop code 00xxx gives no period, 01000..11111 16.5 to 13196.4 ms
// - start/stop code resets to 01111, 125.7 ms
// - internal oscillator measures serial clock rate with no external reference
// - writing 0x00 to trim register enables the factory trim
// - trim bit D6 is read-only, 0 until trim finishes, then 1
// - trim bit D1 resets to 1; writing 0 selects factory trim
// - back-end fault resets power stage and stops all switching at once
// - after a fault, wait the programmed period then restart power stage
// - back-end code 0010 is 299 ms default, steps to 1346, then 1496 ms
// - back-end register takes one non-reserved write after each reset
// - D23 and D19 choose two-level (0) or three-level (1) modulation
// - channel 1 source D22..D20: left 000 default, right 001, zero 110
// - channel 2 source D18..D16: left 000, right 001 default, zero 110
// - output mux routes any internal channel to any of four pins
// - select 0 channel 1, 1 channel 2, 2 and 3 second instances
//
// Decided for this implementation: the APB register port.
`default_nettype none
module pwm_stage_control_regs
   import pwm_stage_pkg::*;
#(
   parameter int unsigned SAMPLE_W           = 24,
   parameter int unsigned CYCLES_PER_TENTH   = TENTH_MS_CYCLES,
   parameter int unsigned TRIM_CYCLES        = 256,
   parameter int unsigned RATE_WINDOW        = 4000
) (
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [pwm_stage_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          all_channel_shutdown,
   input  wire logic                          power_down_pin,
   input  wire logic                          serial_clock,
   input  wire logic [SAMPLE_W-1:0]           serial_input_left,
   input  wire logic [SAMPLE_W-1:0]           serial_input_right,
   output logic      [SAMPLE_W-1:0]           ch1_sample,
   output logic      [SAMPLE_W-1:0]           ch2_sample,
   output logic                               ch1_three_level,
   output logic                               ch2_three_level,
   input  wire logic [3:0]                    pwm_channel,
   output logic      [3:0]                    pwm_pin,
   input  wire logic                          backend_fault,
   output logic                               power_stage_reset,
   output logic                               soft_ramp_active,
   output logic                               trim_done,
   output logic      [15:0]                   rate_count
);
   import pwm_stage_pkg::*;

   // ==========================================================
   // state
   typedef enum logic [1:0] {TR_IDLE, TR_RUN, TR_DONE} trim_e;
   typedef enum logic {BE_RUN, BE_HOLD} backend_e;
   typedef struct packed {
      logic [4:0]          ss_code;
      logic                trim_off;
      trim_e               trim_st;
      logic [15:0]         trim_cnt;
      logic [3:0]          be_code;
      logic                be_locked;
      backend_e            be_st;
      logic [31:0]         be_cnt;
      logic                ch1_bd;
      logic [2:0]          ch1_src;
      logic                ch2_bd;
      logic [2:0]          ch2_src;
      logic [3:0][1:0]     out_sel;
      logic [31:0]         ramp_cnt;
      logic                ramp_on;
      logic [2:0]          pdn_sync;
      logic                pdn_level;
      logic                shut_d;
      logic [2:0]          sclk_sync;
      logic                sclk_level;
      logic [15:0]         rate_win;
      logic [15:0]         rate_edges;
      logic [15:0]         rate_q;
      logic [31:0]         rdata;
      logic                rerr;
      logic [3:0]          pins;
      logic [SAMPLE_W-1:0] s1;
      logic [SAMPLE_W-1:0] s2;
   } state_s;

   state_s s;
   state_s next_s;

   // ==========================================================
   // helpers
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      return ADDR_W'(idx << BYTE_SHIFT);
   endfunction

   function automatic logic src_ok(input logic [2:0] c);
      return (c == SRC_LEFT) || (c == SRC_RIGHT) || (c == SRC_ZERO);
   endfunction

   function automatic logic [SAMPLE_W-1:0] route(input logic [2:0] c);
      unique case (c)
         SRC_LEFT:  return serial_input_left;
         SRC_RIGHT: return serial_input_right;
         default:   return '0;
      endcase
   endfunction

   logic        setup;
   logic        wr;
   logic        ss_event;
   logic        pdn_change;
   logic        sclk_rise;
   logic        be_wr_ok;
   logic [31:0] rd_word;
   logic        rd_hit;

   assign setup = psel && !penable;
   assign wr    = psel && penable && pwrite;

   // ==========================================================
   // read decode
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (paddr == byte_addr(IDX_START_STOP)) begin
         rd_word = 32'(s.ss_code);
      end else if (paddr == byte_addr(IDX_OSC_TRIM)) begin
         rd_word = 32'(TRIM_FIXED);
         rd_word[TRIM_DONE_BIT] = (s.trim_st == TR_DONE);
         rd_word[TRIM_SEL_BIT]  = s.trim_off;
      end else if (paddr == byte_addr(IDX_BACKEND)) begin
         rd_word = 32'(s.be_code);
      end else if (paddr == byte_addr(IDX_INPUT_MUX)) begin
         rd_word = IN_FIXED;
         rd_word[IN_CH1_BD] = s.ch1_bd;
         rd_word[IN_CH1_SRC +: 3] = s.ch1_src;
         rd_word[IN_CH2_BD] = s.ch2_bd;
         rd_word[IN_CH2_SRC +: 3] = s.ch2_src;
      end else if (paddr == byte_addr(IDX_OUTPUT_MUX)) begin
         rd_word = OUT_FIXED;
         rd_word[OUT_POS_A +: 2] = s.out_sel[0];
         rd_word[OUT_POS_B +: 2] = s.out_sel[1];
         rd_word[OUT_POS_C +: 2] = s.out_sel[2];
         rd_word[OUT_POS_D +: 2] = s.out_sel[3];
      end else begin
         rd_hit = 1'b0;
      end
   end

   // non-reserved value and not yet written since reset
   assign be_wr_ok = !s.be_locked && (pwdata[7:4] == 4'h0)
                     && (pwdata[3:0] >= BE_MIN_CODE);

   assign pdn_change = (s.pdn_sync[1] == s.pdn_sync[2])
                       && (s.pdn_sync[2] != s.pdn_level);
   assign sclk_rise  = (s.sclk_sync[1] == s.sclk_sync[2])
                       && s.sclk_sync[2] && !s.sclk_level;
   assign ss_event   = pdn_change
                       || (all_channel_shutdown != s.shut_d);

   // ==========================================================
   // next state
   always_comb begin
      next_s = s;
      // apb read data captured in the setup phase
      if (setup) begin
         next_s.rdata = rd_word;
         next_s.rerr  = !rd_hit || (paddr[BYTE_SHIFT-1:0] != '0);
      end
      // register writes at the access phase
      if (wr && rd_hit) begin
         if (paddr == byte_addr(IDX_START_STOP)) begin
            next_s.ss_code = pwdata[4:0];
         end
         if (paddr == byte_addr(IDX_OSC_TRIM)) begin
            next_s.trim_off = pwdata[TRIM_SEL_BIT];
            if (!pwdata[TRIM_SEL_BIT]) begin
               next_s.trim_st  = TR_RUN;
               next_s.trim_cnt = 16'(TRIM_CYCLES - 1);
            end else begin
               next_s.trim_st  = TR_IDLE;
            end
         end
         if (paddr == byte_addr(IDX_BACKEND) && be_wr_ok) begin
            next_s.be_code   = pwdata[3:0];
            next_s.be_locked = 1'b1;
         end
         if (paddr == byte_addr(IDX_INPUT_MUX)) begin
            next_s.ch1_bd = pwdata[IN_CH1_BD];
            next_s.ch2_bd = pwdata[IN_CH2_BD];
            if (src_ok(pwdata[IN_CH1_SRC +: 3])) begin
               next_s.ch1_src = pwdata[IN_CH1_SRC +: 3];
            end
            if (src_ok(pwdata[IN_CH2_SRC +: 3])) begin
               next_s.ch2_src = pwdata[IN_CH2_SRC +: 3];
            end
         end
         if (paddr == byte_addr(IDX_OUTPUT_MUX)) begin
            next_s.out_sel[0] = pwdata[OUT_POS_A +: 2];
            next_s.out_sel[1] = pwdata[OUT_POS_B +: 2];
            next_s.out_sel[2] = pwdata[OUT_POS_C +: 2];
            next_s.out_sel[3] = pwdata[OUT_POS_D +: 2];
         end
      end
      // oscillator trim sequence
      // completion wins over a disabling write, only a restart pre-empts it
      if (s.trim_st == TR_RUN && !(wr && paddr == byte_addr(IDX_OSC_TRIM)
          && !pwdata[TRIM_SEL_BIT])) begin
         if (s.trim_cnt == '0) begin
            next_s.trim_st = TR_DONE;
         end else begin
            next_s.trim_cnt = s.trim_cnt - 16'h1;
         end
      end
      // power-down pin and serial clock filters
      next_s.pdn_sync  = {s.pdn_sync[1:0], power_down_pin};
      next_s.sclk_sync = {s.sclk_sync[1:0], serial_clock};
      if (s.pdn_sync[1] == s.pdn_sync[2]) begin
         next_s.pdn_level = s.pdn_sync[2];
      end
      if (s.sclk_sync[1] == s.sclk_sync[2]) begin
         next_s.sclk_level = s.sclk_sync[2];
      end
      next_s.shut_d = all_channel_shutdown;
      // soft start/stop period
      if (ss_event) begin
         next_s.ramp_on  = (s.ss_code[4:3] != 2'h0);
         next_s.ramp_cnt = 32'(ss_tenths(s.ss_code) * CYCLES_PER_TENTH);
      end else if (s.ramp_on) begin
         next_s.ramp_cnt = s.ramp_cnt - 32'h1;
         if (s.ramp_cnt <= 32'h1) begin
            next_s.ramp_on = 1'b0;
         end
      end
      // rate measurement, only meaningful once trimmed
      if (s.trim_st == TR_DONE) begin
         if (s.rate_win == '0) begin
            next_s.rate_q     = s.rate_edges;
            next_s.rate_edges = 16'(sclk_rise);
            next_s.rate_win   = 16'(RATE_WINDOW - 1);
         end else begin
            next_s.rate_win   = s.rate_win - 16'h1;
            next_s.rate_edges = s.rate_edges + 16'(sclk_rise);
         end
      end else begin
         next_s.rate_win   = 16'(RATE_WINDOW - 1);
         next_s.rate_edges = '0;
      end
      // back-end fault recovery
      unique case (s.be_st)
         BE_RUN: begin
            if (backend_fault) begin
               next_s.be_st  = BE_HOLD;
               next_s.be_cnt = 32'(be_ms(s.be_code) * TENTHS_PER_MS
                                   * CYCLES_PER_TENTH);
            end
         end
         BE_HOLD: begin
            if (backend_fault) begin
               next_s.be_cnt = 32'(be_ms(s.be_code) * TENTHS_PER_MS
                                   * CYCLES_PER_TENTH);
            end else if (s.be_cnt <= 32'h1) begin
               next_s.be_st = BE_RUN;
            end else begin
               next_s.be_cnt = s.be_cnt - 32'h1;
            end
         end
      endcase
      // output pin mux, switching stopped while the stage is held
      for (int i = 0; i < 4; i++) begin
         next_s.pins[i] = pwm_channel[s.out_sel[i]];
      end
      if (backend_fault || next_s.be_st == BE_HOLD) begin
         next_s.pins = '0;
      end
      // input routing to internal channels
      next_s.s1 = route(s.ch1_src);
      next_s.s2 = route(s.ch2_src);
   end

   // ==========================================================
   // registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s            <= '0;
         s.ss_code    <= SS_RESET;
         s.trim_off   <= 1'b1;
         s.trim_st    <= TR_IDLE;
         s.be_code    <= BE_RESET;
         s.be_st      <= BE_RUN;
         s.ch1_src    <= SRC_LEFT;
         s.ch2_src    <= SRC_RIGHT;
         s.out_sel    <= OUT_SEL_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs
   assign pready            = psel && penable;
   assign prdata            = s.rdata;
   assign pslverr           = pready && s.rerr;
   assign ch1_sample        = s.s1;
   assign ch2_sample        = s.s2;
   assign ch1_three_level   = s.ch1_bd;
   assign ch2_three_level   = s.ch2_bd;
   assign pwm_pin           = s.pins;
   assign power_stage_reset = (s.be_st == BE_HOLD);
   assign soft_ramp_active  = s.ramp_on;
   assign trim_done         = (s.trim_st == TR_DONE);
   assign rate_count        = s.rate_q;

   // ==========================================================
   // checks
   AST_RAMP_START: assert property (@(posedge mclk) disable iff (!resetn)
      ss_event && s.ss_code[4:3] != 2'h0 |=> soft_ramp_active)
      else $error("soft period did not start");
   AST_RAMP_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(soft_ramp_active) |-> $past(ss_event)
      && $past(s.ss_code[4:3]) != 2'h0)
      else $error("soft period started without cause");
   AST_RESET_CODE: assert property (@(posedge mclk)
      $rose(resetn) |-> s.ss_code == SS_RESET && s.trim_off)
      else $error("wrong reset values");
   AST_TRIM_START: assert property (@(posedge mclk) disable iff (!resetn)
      wr && paddr == byte_addr(IDX_OSC_TRIM) && pwdata == 32'h0
      |=> s.trim_st == TR_RUN ##1 !trim_done)
      else $error("trim write did not start trim");
   AST_TRIM_DONE: assert property (@(posedge mclk) disable iff (!resetn)
      s.trim_st == TR_RUN && s.trim_cnt == '0
      && !(wr && paddr == byte_addr(IDX_OSC_TRIM))
      |=> trim_done)
      else $error("trim done flag not set");
   AST_FAULT_STOP: assert property (@(posedge mclk) disable iff (!resetn)
      backend_fault |=> pwm_pin == 4'h0 && power_stage_reset)
      else $error("switching not stopped on fault");
   AST_RESTART: assert property (@(posedge mclk) disable iff (!resetn)
      s.be_st == BE_HOLD && s.be_cnt == 32'h1 && !backend_fault
      |=> !power_stage_reset)
      else $error("power stage not restarted");
   AST_WRITE_ONCE: assert property (@(posedge mclk) disable iff (!resetn)
      s.be_locked && wr && paddr == byte_addr(IDX_BACKEND)
      |=> $stable(s.be_code))
      else $error("back-end register written twice");
   AST_SRC_RESERVED: assert property (@(posedge mclk) disable iff (!resetn)
      wr && paddr == byte_addr(IDX_INPUT_MUX)
      && !src_ok(pwdata[IN_CH1_SRC +: 3]) |=> $stable(s.ch1_src))
      else $error("reserved source code accepted");
   AST_OUT_ROUTE: assert property (@(posedge mclk) disable iff (!resetn)
      s.be_st == BE_RUN && !backend_fault && !$past(backend_fault)
      ##1 s.be_st == BE_RUN
      |-> pwm_pin[1] == $past(pwm_channel[s.out_sel[1]]))
      else $error("output pin not routed");
endmodule
`default_nettype wire

// ===== verification/apb_host_model.sv
// apb master standing in for the host controller
// assumes mclk from the bench; waits on pready, no fixed latency
`default_nettype none
module apb_host_model (
   input  wire logic        mclk,
   input  wire logic        pready,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // one transfer, held until pready
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verification/tb_pwm_stage_control_regs.sv
// bench for the modulator and power stage control registers
// assumes sim values 2 cycles per 0.1 ms, trim 4, rate window 16
`default_nettype none
module tb_pwm_stage_control_regs;
   import pwm_stage_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // signals
   logic mclk = 0, resetn = 0, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rnd = 32'h3247;
   logic all_channel_shutdown = 0, power_down_pin = 0, serial_clock = 0;
   logic backend_fault = 0, power_stage_reset, soft_ramp_active, trim_done;
   logic [23:0] serial_input_left = 0, serial_input_right = 0;
   logic [23:0] ch1_sample, ch2_sample;
   logic ch1_three_level, ch2_three_level;
   logic [3:0] pwm_channel = 0, pwm_pin;
   logic [15:0] rate_count;
   logic [1:0] sdiv = 0;
   logic [32:0] exp_q [$];
   int err_count = 0, total_checks = 0, n;
   logic [31:0] im_w [3] = '{32'h00e07772, 32'h001e7772, 32'h00a07772};
   logic [31:0] im_r [3] = '{32'h00e07772, 32'h001e7772, 32'h00907772};
   logic [31:0] om_w [2] = '{32'h01321000, 32'hffe4ffff};
   logic [31:0] om_r [2] = '{32'h01321000, 32'h01203300};
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      sdiv <= sdiv + 2'h1;
      serial_clock <= sdiv[1];
   end
   pwm_stage_control_regs #(.SAMPLE_W(24), .CYCLES_PER_TENTH(2),
      .TRIM_CYCLES(4), .RATE_WINDOW(16)) i_pwm_stage_control_regs (.*);
   apb_host_model i_apb_host_model (.mclk, .pready, .psel, .penable,
      .pwrite, .paddr, .pwdata);
   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [23:0] pick(input logic [2:0] s);
      return (s == SRC_RIGHT) ? serial_input_right :
             (s == SRC_ZERO) ? 24'h0 : serial_input_left;
   endfunction
   function automatic logic [3:0] pins(input logic [31:0] r);
      logic [3:0] p;
      for (int k = 0; k < 4; k++) p[k] = pwm_channel[r[OUT_POS_A-4*k +: 2]];
      return p;
   endfunction
   task automatic chk(input string nm, input logic [32:0] e,
                      input logic [32:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      i_apb_host_model.xfer(1'b1, 8'(i << BYTE_SHIFT), d);
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] e,
                     input logic er);
      exp_q.push_back({er, e});
      i_apb_host_model.xfer(1'b0, 8'(i << BYTE_SHIFT), 32'h0);
   endtask
   task automatic tick;
      @(posedge mclk);
      rnd = lfsr(rnd);
      pwm_channel <= rnd[3:0];
      serial_input_left <= rnd[31:8];
      serial_input_right <= rnd[23:0];
      @(posedge mclk);
      #1;
   endtask
   task automatic ramp(input logic pin, input int e);
      n = 0;
      @(posedge mclk);
      if (pin) power_down_pin <= ~power_down_pin;
      else all_channel_shutdown <= ~all_channel_shutdown;
      repeat (400) begin
         @(posedge mclk);
         n += int'(soft_ramp_active === 1'b1);
      end
      chk("ramp", 33'(e), 33'(n));
   endtask
   // ==========================================
   // read monitor takes the oldest note
   always @(posedge mclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("prdata", exp_q.pop_front(), {pslverr, prdata});
   initial begin
      #(40000 * 25);
      err_count++;
      end_sim();
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      rd(IDX_START_STOP, 32'h0f, 0);
      rd(IDX_OSC_TRIM, 32'h82, 0);
      rd(IDX_BACKEND, 32'h02, 0);
      rd(IDX_INPUT_MUX, 32'h00017772, 0);
      rd(IDX_OUTPUT_MUX, 32'h01012300, 0);
      rd(8'h1d, 32'h0, 1);
      wr(IDX_START_STOP, 32'hffffffe8);
      rd(IDX_START_STOP, 32'h08, 0);
      ramp(0, 330);
      ramp(1, 330);
      wr(IDX_START_STOP, 32'h07);
      ramp(0, 0);
      wr(IDX_OSC_TRIM, 32'h0);
      rd(IDX_OSC_TRIM, 32'h80, 0);
      repeat (8) @(posedge mclk);
      chk("trim_done", 1, trim_done);
      rd(IDX_OSC_TRIM, 32'hc0, 0);
      repeat (40) @(posedge mclk);
      chk("rate_count", 4, rate_count);
      wr(IDX_OSC_TRIM, 32'hff);
      rd(IDX_OSC_TRIM, 32'h82, 0);
      foreach (im_w[i]) begin
         wr(IDX_INPUT_MUX, im_w[i]);
         rd(IDX_INPUT_MUX, im_r[i], 0);
         tick();
         chk("ch1", pick(im_r[i][22:20]), ch1_sample);
         chk("ch2", pick(im_r[i][18:16]), ch2_sample);
         chk("mode", {im_r[i][23], im_r[i][19]},
             {ch1_three_level, ch2_three_level});
      end
      foreach (om_w[i]) begin
         wr(IDX_OUTPUT_MUX, om_w[i]);
         rd(IDX_OUTPUT_MUX, om_r[i], 0);
         repeat (4) begin
            tick();
            chk("pin", pins(om_r[i]), pwm_pin);
         end
      end
      wr(IDX_BACKEND, 32'h11);
      rd(IDX_BACKEND, 32'h02, 0);
      wr(IDX_BACKEND, 32'h03);
      wr(IDX_BACKEND, 32'h0a);
      rd(IDX_BACKEND, 32'h03, 0);
      @(posedge mclk);
      pwm_channel <= 4'hf;
      backend_fault <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk("stage_reset", 1, power_stage_reset);
      chk("pin_stop", 0, pwm_pin);
      backend_fault <= 1'b0;
      n = 0;
      repeat (9100) begin
         @(posedge mclk);
         n += int'(power_stage_reset === 1'b1);
      end
      chk("wait", 1, n >= 8980 && n <= 8990);
      end_sim();
   end
endmodule
`default_nettype wire
